//--- otc_regs.sv
`timescale 1ns/1ps
module otc_regs
  import otc_pkg::*;
#(
  parameter int ADDR_W   = 12,
  parameter int STEP_CYC = STEP_CYCLES
)
(
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  input  wire logic                               hsel,
  input  wire logic [ADDR_W-1:0]                  haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic      [31:0]                        hrdata,
  output logic                                    hreadyout,
  output logic                                    hresp,
  output logic                                    irq,
  input  wire logic                               overtemp_line_in_n,
  output logic                                    overtemp_line_out,
  output logic                                    overtemp_line_oe,
  input  wire logic [2:0]                         channel_over_limit,
  input  wire logic [7:0]                         remote_one_overtemp_limit,
  input  wire logic [7:0]                         local_overtemp_limit,
  input  wire logic [7:0]                         remote_two_overtemp_limit,
  input  wire logic                               general_pin_func_en,
  input  wire logic                               general_pin_six_in,
  output logic                                    general_pin_six_out,
  output logic                                    general_pin_six_oe,
  output logic                                    temp_format_twos,
  output logic                                    temp_offset_wide,
  output logic                                    ident_pin_select,
  output logic      [NUM_COOLERS*PULSE_CNT_W-1:0] cooler_pulse_count
);

  // =====================================================================
  // declarations
  // =====================================================================
  otc_timer_if tif ();

  otc_phase_t  phase;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        addr_take;
  logic        word_ok;
  logic [7:0]  req_idx;
  logic        wr_en;
  logic [7:0]  wr_byte;

  logic [7:0]  assert_duration_limit;
  logic [7:0]  tach_pulse_count_select;
  logic [7:0]  config_five;
  logic [7:0]  int_status_two;
  logic [7:0]  int_mask_two;
  logic        config_lock;
  logic        general_pin_drive;

  logic        line_sync1;
  logic        line_sync2;
  logic        line_q;
  logic        gp_sync1;
  logic        gp_sync2;
  logic [2:0]  channel_drive;
  logic [7:0]  channel_limit [3];
  logic [2:0]  channel_en;

  // limit code that switches a channel off for the current coding
  function automatic logic limit_disabled(input logic [7:0] lim, input logic twos);
    limit_disabled = twos ? (lim == LIMIT_OFF_TWOS) : (lim == LIMIT_OFF_OFFSET64);
  endfunction

  // register read mux, reserved bits read zero
  function automatic logic [7:0] read_value(input logic [7:0] idx);
    case (idx)
      IDX_INT_STATUS_TWO: read_value = int_status_two;
      IDX_TMR_STATUS:     read_value = tif.status_view;
      IDX_TMR_LIMIT:      read_value = assert_duration_limit;
      IDX_TACH_PULSE_SEL: read_value = tach_pulse_count_select;
      IDX_CONFIG_FIVE:    read_value = config_five;
      IDX_INT_MASK_TWO:   read_value = int_mask_two;
      IDX_CONFIG_LOCK:    read_value = {7'h00, config_lock};
      IDX_GENERAL_PIN:    read_value = {6'h00, gp_sync2, general_pin_drive};
      default:            read_value = 8'h00;
    endcase
  endfunction

  // =====================================================================
  // bus slave
  // =====================================================================
  // address phase decode, only aligned word transfers are mapped
  assign addr_take = hsel && htrans[1] && hready;
  assign word_ok   = (haddr[1:0] == 2'b00) && (hsize == 3'b010)
                  && (haddr[ADDR_W-1:10] == '0);
  assign req_idx   = word_ok ? haddr[9:2] : 8'hff;

  // transfer phase tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase  <= OTC_IDLE;
      wr_idx <= 8'h00;
      rd_idx <= 8'h00;
    end
    else if (addr_take)
    begin
      phase  <= hwrite ? OTC_WRITE : OTC_READ_WAIT;
      wr_idx <= req_idx;
      rd_idx <= req_idx;
    end
    else if (phase != OTC_READ_WAIT || hreadyout)
      phase  <= OTC_IDLE;
  end

  // reads take one wait state so a preceding write is always visible;
  // a read taken in the last cycle of an earlier read still gets its wait state
  // responses are always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
      hresp     <= 1'b0;
    end
    else if (phase == OTC_READ_WAIT && !hreadyout)
    begin
      hreadyout <= 1'b1;
      hrdata    <= {24'h0, read_value(rd_idx)};
    end
    else
      hreadyout <= !(addr_take && !hwrite);
  end

  // write strobe in the data phase
  assign wr_en   = (phase == OTC_WRITE);
  assign wr_byte = hwdata[7:0];

  // a status read clears the timer when its data is fetched
  assign tif.rd_clear = (phase == OTC_READ_WAIT) && !hreadyout
                     && (rd_idx == IDX_TMR_STATUS);

  // =====================================================================
  // software registers
  // =====================================================================
  // duration limit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      assert_duration_limit <= RST_TMR_LIMIT;
    else if (wr_en && wr_idx == IDX_TMR_LIMIT)
      assert_duration_limit <= wr_byte;
  end

  // pulses per measurement selection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tach_pulse_count_select <= RST_TACH_PULSE_SEL;
    else if (wr_en && wr_idx == IDX_TACH_PULSE_SEL)
      tach_pulse_count_select <= wr_byte;
  end

  // config five, frozen while locked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      config_five <= RST_CONFIG_FIVE;
    else if (wr_en && wr_idx == IDX_CONFIG_FIVE && !config_lock)
      config_five <= wr_byte;
  end

  // lock bit, set by software and only reset clears it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      config_lock <= 1'b0;
    else if (wr_en && wr_idx == IDX_CONFIG_LOCK && wr_byte[BIT_LOCK])
      config_lock <= 1'b1;
  end

  // general pin drive level and interrupt mask
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      general_pin_drive <= 1'b0;
      int_mask_two      <= RST_ZERO;
    end
    else if (wr_en)
    begin
      if (wr_idx == IDX_GENERAL_PIN)
        general_pin_drive <= wr_byte[BIT_GP_DRIVE];
      if (wr_idx == IDX_INT_MASK_TWO)
        int_mask_two <= wr_byte & (8'h01 << BIT_DURATION_FLAG);
    end
  end

  // =====================================================================
  // interrupt status
  // =====================================================================
  // sticky flag, write one to clear, a new event wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_status_two <= RST_ZERO;
    else if (tif.limit_hit)
      int_status_two[BIT_DURATION_FLAG] <= 1'b1;
    else if (wr_en && wr_idx == IDX_INT_STATUS_TWO && wr_byte[BIT_DURATION_FLAG])
      int_status_two[BIT_DURATION_FLAG] <= 1'b0;
  end

  // level interrupt from unmasked flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(int_status_two & int_mask_two);
  end

  // =====================================================================
  // overtemp line
  // =====================================================================
  // two flop synchronisers for both pins, then an edge register on the line
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      line_sync1 <= 1'b0;
      line_sync2 <= 1'b0;
      line_q     <= 1'b0;
      gp_sync1   <= 1'b0;
      gp_sync2   <= 1'b0;
    end
    else
    begin
      line_sync1 <= !overtemp_line_in_n;
      line_sync2 <= line_sync1;
      line_q     <= line_sync2;
      gp_sync1   <= general_pin_six_in;
      gp_sync2   <= gp_sync1;
    end
  end

  assign tif.line_asserted = line_sync2;
  assign tif.line_rise     = line_sync2 && !line_q;
  assign tif.limit         = assert_duration_limit;

  // channels that may pull the line low
  assign channel_limit[0] = remote_one_overtemp_limit;
  assign channel_limit[1] = local_overtemp_limit;
  assign channel_limit[2] = remote_two_overtemp_limit;
  assign channel_en = {config_five[BIT_REMOTE_TWO_EN], config_five[BIT_LOCAL_EN],
                       config_five[BIT_REMOTE_ONE_EN]};

  generate
    for (genvar ch = 0; ch < 3; ch++)
    begin : g_channel
      assign channel_drive[ch] = channel_en[ch] && channel_over_limit[ch]
                              && !limit_disabled(channel_limit[ch],
                                                 config_five[BIT_FMT_TWOS]);
    end
  endgenerate

  // open drain, low level only while some channel drives
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      overtemp_line_out <= 1'b0;
      overtemp_line_oe  <= 1'b0;
    end
    else
    begin
      overtemp_line_out <= 1'b0;
      overtemp_line_oe  <= |channel_drive;
    end
  end

  // =====================================================================
  // general purpose pin
  // =====================================================================
  // direction and polarity of the pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      general_pin_six_oe  <= 1'b0;
      general_pin_six_out <= 1'b0;
    end
    else
    begin
      general_pin_six_oe  <= general_pin_func_en && config_five[BIT_GP_DIRECTION];
      general_pin_six_out <= config_five[BIT_GP_POLARITY] ? general_pin_drive
                                                          : !general_pin_drive;
    end
  end

  // =====================================================================
  // configuration outputs
  // =====================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      temp_format_twos <= RST_CONFIG_FIVE[BIT_FMT_TWOS];
      temp_offset_wide <= 1'b0;
      ident_pin_select <= 1'b0;
    end
    else
    begin
      temp_format_twos <= config_five[BIT_FMT_TWOS];
      temp_offset_wide <= config_five[BIT_OFFSET_WIDE];
      ident_pin_select <= config_five[BIT_IDENT_SELECT];
    end
  end

  // pulses counted per fan, code plus one
  generate
    for (genvar f = 0; f < NUM_COOLERS; f++)
    begin : g_cooler
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          cooler_pulse_count[f*PULSE_CNT_W +: PULSE_CNT_W] <= 3'd2;
        else
          cooler_pulse_count[f*PULSE_CNT_W +: PULSE_CNT_W] <=
            {1'b0, tach_pulse_count_select[f*PULSE_SEL_W +: PULSE_SEL_W]} + 3'd1;
      end
    end
  endgenerate

  // =====================================================================
  // duration timer
  // =====================================================================
  otc_duration_timer #(
    .STEP_CYC (STEP_CYC)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif.timer)
  );

endmodule

//--- otc_pkg.sv
// =====================================================================
// shared constants for the overtemp timer and configuration registers
// =====================================================================
package otc_pkg;

  // =====================================================================
  // register indexes (byte address is four times the index)
  // =====================================================================
  localparam logic [7:0] IDX_INT_STATUS_TWO  = 8'h42;
  localparam logic [7:0] IDX_TMR_STATUS      = 8'h79;
  localparam logic [7:0] IDX_TMR_LIMIT       = 8'h7a;
  localparam logic [7:0] IDX_TACH_PULSE_SEL  = 8'h7b;
  localparam logic [7:0] IDX_CONFIG_FIVE     = 8'h7c;
  localparam logic [7:0] IDX_INT_MASK_TWO    = 8'h80;
  localparam logic [7:0] IDX_CONFIG_LOCK     = 8'h81;
  localparam logic [7:0] IDX_GENERAL_PIN     = 8'h82;

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic [7:0] RST_TMR_LIMIT       = 8'h00;
  localparam logic [7:0] RST_TACH_PULSE_SEL  = 8'h55;
  localparam logic [7:0] RST_CONFIG_FIVE     = 8'h01;
  localparam logic [7:0] RST_ZERO            = 8'h00;

  // =====================================================================
  // field positions
  // =====================================================================
  localparam int BIT_FMT_TWOS       = 0;
  localparam int BIT_OFFSET_WIDE    = 1;
  localparam int BIT_GP_DIRECTION   = 2;
  localparam int BIT_GP_POLARITY    = 3;
  localparam int BIT_IDENT_SELECT   = 4;
  localparam int BIT_REMOTE_ONE_EN  = 5;
  localparam int BIT_LOCAL_EN       = 6;
  localparam int BIT_REMOTE_TWO_EN  = 7;
  localparam int BIT_DURATION_FLAG  = 5;
  localparam int BIT_LOCK           = 0;
  localparam int BIT_GP_DRIVE       = 0;
  localparam int BIT_GP_LEVEL       = 1;
  localparam int PULSE_SEL_W        = 2;
  localparam int PULSE_CNT_W        = 3;
  localparam int NUM_COOLERS        = 4;

  // =====================================================================
  // limit codes meaning a channel limit is disabled
  // =====================================================================
  localparam logic [7:0] LIMIT_OFF_OFFSET64  = 8'h00;
  localparam logic [7:0] LIMIT_OFF_TWOS      = 8'h80;

  // =====================================================================
  // timing
  // =====================================================================
  localparam int CLK_PERIOD_NS     = 20;
  localparam int STEP_TIME_NS      = 22760000;
  localparam int STEP_CYCLES       = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] REPORT_MIN_STEPS = 8'h02;

  // bus transfer phases
  typedef enum logic [1:0] {OTC_IDLE, OTC_WRITE, OTC_READ_WAIT} otc_phase_t;

endpackage

//--- otc_timer_if.sv
`timescale 1ns/1ps
// =====================================================================
// link between the register bank and the duration timer
// =====================================================================
interface otc_timer_if;
  logic       line_asserted;
  logic       line_rise;
  logic       rd_clear;
  logic [7:0] limit;
  logic [7:0] status_view;
  logic       limit_hit;

  modport ctrl
  (
    output line_asserted,
    output line_rise,
    output rd_clear,
    output limit,
    input  status_view,
    input  limit_hit
  );

  modport timer
  (
    input  line_asserted,
    input  line_rise,
    input  rd_clear,
    input  limit,
    output status_view,
    output limit_hit
  );
endinterface

//--- otc_duration_timer.sv
`timescale 1ns/1ps
// =====================================================================
// measures how long the overtemp line stays asserted
// =====================================================================
module otc_duration_timer
  import otc_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  otc_timer_if.timer tif
);

  logic [31:0] step_div;
  logic        step_tick;
  logic [7:0]  duration;
  logic        seen;
  logic        over_limit;
  logic        over_limit_q;

  // step divider runs only while the line is asserted
  assign step_tick = tif.line_asserted && (step_div == 32'(STEP_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      step_div <= 32'h0;
    else if (!tif.line_asserted || tif.line_rise || step_tick)
      step_div <= 32'h0;
    else
      step_div <= step_div + 32'h1;
  end

  // duration count, cleared by a status read, saturating at the top
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      duration <= 8'h00;
    else if (step_tick && duration != 8'hff)
      duration <= tif.rd_clear ? 8'h01 : duration + 8'h01;
    else if (tif.rd_clear)
      duration <= 8'h00;
  end

  // assertion seen flag, a new assertion wins over the read clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      seen <= 1'b0;
    else if (tif.line_rise)
      seen <= 1'b1;
    else if (tif.rd_clear)
      seen <= 1'b0;
  end

  // short assertions show only the seen flag
  assign tif.status_view = (duration >= REPORT_MIN_STEPS) ? duration
                                                          : {7'h00, seen};

  // limit compare, zero limit fires on the assertion itself
  assign over_limit = tif.line_asserted && (tif.limit != 8'h00) && (duration > tif.limit);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      over_limit_q <= 1'b0;
    else
      over_limit_q <= over_limit;
  end

  assign tif.limit_hit = (over_limit && !over_limit_q)
                      || (tif.line_rise && tif.limit == 8'h00);

endmodule

//--- otc_regs_assertions.sv
`timescale 1ns/1ps
// ==========
// port checks for the register bank
module otc_chk
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq,
  input wire logic        overtemp_line_out,
  input wire logic        overtemp_line_oe,
  input wire logic [2:0]  channel_over_limit,
  input wire logic        general_pin_func_en,
  input wire logic        general_pin_six_oe,
  input wire logic        temp_format_twos,
  input wire logic [11:0] cooler_pulse_count
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // transfers taken at an edge
  logic rd_tk;
  logic wr_tk;
  assign rd_tk = hsel & htrans[1] & hready & !hwrite;
  assign wr_tk = hsel & htrans[1] & hready & hwrite;
  // every pulse field decodes to one..four
  function automatic logic fld_ok(input logic [11:0] c);
    fld_ok = 1'b1;
    for (int f = 0; f < 4; f++)
      if (c[3*f +: 3] == 3'h0 || c[3*f +: 3] > 3'h4) fld_ok = 1'b0;
  endfunction
  AST_READ_WAIT: assert property (rd_tk |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (wr_tk |=> hreadyout)
    else $error("write stalled");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response");
  AST_LINE_LOW: assert property (overtemp_line_out == 1'b0)
    else $error("line output not low");
  AST_OE_CAUSE: assert property (overtemp_line_oe |-> $past(|channel_over_limit))
    else $error("line driven without cause");
  AST_GP_OE: assert property (general_pin_six_oe |-> $past(general_pin_func_en))
    else $error("pin driven while disabled");
  AST_PULSE_RANGE: assert property (fld_ok(cooler_pulse_count))
    else $error("pulse count out of range");
  AST_PULSE_BY_WRITE: assert property ($changed(cooler_pulse_count)
    |-> $past(wr_tk, 2) || $past(wr_tk, 3))
    else $error("pulse count changed without write");
  AST_FORMAT_RESET: assert property ($rose(hresetn) |-> temp_format_twos)
    else $error("format bit not set after reset");
  COV_READ: cover property (rd_tk);
  COV_IRQ: cover property ($rose(irq));
  COV_LINE: cover property ($rose(overtemp_line_oe));
endmodule

bind otc_regs otc_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .irq, .overtemp_line_out, .overtemp_line_oe,
  .channel_over_limit, .general_pin_func_en, .general_pin_six_oe,
  .temp_format_twos, .cooler_pulse_count);

//--- otc_host_model.sv
`timescale 1ns/1ps
// ==========
// bus master standing in for the management controller
module otc_host_model
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // address phase held until the slave takes it
  task automatic addr_ph(input logic [7:0] idx, input logic wr);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {2'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
  endtask
  // data phase ends on ready; stale write data is inverted
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    addr_ph(idx, 1'b1);
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    hwdata <= ~{24'h0, d};
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    addr_ph(idx, 1'b0);
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
    hsel <= 1'b0;
  endtask
endmodule

//--- otc_regs_tb.sv
`timescale 1ns/1ps
// ==========
// register bank bench
module otc_regs_tb;
  logic        hclk, hresetn, ext_n, gp_en, hsel, hwrite;
  logic        hready, hresp, irq, ot_out, ot_oe, gp_out, gp_oe;
  logic        fmt, wide, ident;
  logic [1:0]  htrans;
  logic [2:0]  over, hsize;
  logic [7:0]  loc_lim;
  logic [11:0] haddr, cool;
  logic [31:0] hwdata, hrdata, rd;
  logic [16:0] rows [10];
  int          miscompares, tests_run, cyc;

  // line pulled up, low when either side pulls
  otc_regs #(.STEP_CYC(8)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
    .irq, .overtemp_line_in_n(ext_n & ~ot_oe), .overtemp_line_out(ot_out),
    .overtemp_line_oe(ot_oe), .channel_over_limit(over),
    .remote_one_overtemp_limit(8'h10), .local_overtemp_limit(loc_lim),
    .remote_two_overtemp_limit(8'h10), .general_pin_func_en(gp_en),
    .general_pin_six_in(1'b1), .general_pin_six_out(gp_out),
    .general_pin_six_oe(gp_oe), .temp_format_twos(fmt),
    .temp_offset_wide(wide), .ident_pin_select(ident), .cooler_pulse_count(cool));
  otc_host_model host (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata);

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
    host.rd(idx, rd);
    chk(nm, e, rd);
  endtask
  // hold the line low for n cycles, then let it settle
  task automatic pulse(input int n);
    @(posedge hclk);
    ext_n <= 1'b0;
    repeat (n) @(posedge hclk);
    ext_n <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    {ext_n, gp_en, hresetn, over, loc_lim} = {3'h4, 3'h0, 8'h10};
    {miscompares, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
    rows = '{17'h07a00, 17'h07b55, 17'h07c01, 17'h07900, 17'h17be4,
      17'h07be4, 17'h17d5a, 17'h07d00, 17'h17a01, 17'h07a01};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
      if (rows[i][16])
        host.wr(rows[i][15:8], rows[i][7:0]);
      else
        rdc("table read", rows[i][15:8], {24'h0, rows[i][7:0]});
    repeat (3) @(posedge hclk);
    chk("pulse counts", 32'h8d1, {20'h0, cool});
    $display("test table done");
    host.wr(8'h80, 8'h20);
    pulse(12);
    rdc("short assert", 8'h79, 32'h1);
    rdc("cleared", 8'h79, 32'h0);
    rdc("no flag", 8'h42, 32'h0);
    pulse(30);
    rdc("long assert", 8'h79, 32'h3);
    rdc("flag", 8'h42, 32'h20);
    chk("irq set", 32'h1, 32'(irq));
    host.wr(8'h42, 8'h20);
    repeat (3) @(posedge hclk);
    chk("irq clear", 32'h0, 32'(irq));
    host.wr(8'h7a, 8'h00);
    pulse(2);
    rdc("zero limit", 8'h42, 32'h20);
    pulse(2100);
    rdc("saturate", 8'h79, 32'hff);
    $display("test timer done");
    host.wr(8'h7c, 8'hfe);
    host.wr(8'h82, 8'h01);
    gp_en <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("format", 32'h0, 32'(fmt));
    chk("offset range", 32'h1, 32'(wide));
    chk("ident select", 32'h1, 32'(ident));
    chk("pin output", 32'h1, 32'(gp_oe));
    chk("active high", 32'h1, 32'(gp_out));
    host.wr(8'h7c, 8'hf6);
    over <= 3'h2;
    repeat (3) @(posedge hclk);
    chk("active low", 32'h0, 32'(gp_out));
    chk("line driven", 32'h1, 32'(ot_oe));
    loc_lim <= 8'h00;
    repeat (3) @(posedge hclk);
    chk("limit off", 32'h0, 32'(ot_oe));
    host.wr(8'h7c, 8'hf7);
    repeat (3) @(posedge hclk);
    chk("twos format", 32'h1, 32'(fmt));
    chk("twos limit on", 32'h1, 32'(ot_oe));
    loc_lim <= 8'h80;
    repeat (3) @(posedge hclk);
    chk("twos limit off", 32'h0, 32'(ot_oe));
    over <= 3'h0;
    host.wr(8'h81, 8'h01);
    host.wr(8'h7c, 8'h01);
    rdc("locked", 8'h7c, 32'hf7);
    $display("test config done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk("reset irq", 32'h0, 32'(irq));
    rdc("reset config", 8'h7c, 32'h01);
    rdc("reset lock", 8'h81, 32'h0);
    host.wr(8'h7c, 8'h03);
    rdc("unlocked", 8'h7c, 32'h03);
    $display("test reset done");
    wrap_up();
  end
endmodule
